/* File: hdl/dlb_ctrl.sv */
// Contract
// - Separate read/write control registers for the diagnostic LED and the buzzer.
// - Bit 0 enable, bit 1 select low, bit 2 select high; rest unused.
// - With LED enable set, the LED shows the selected pattern.
// - LED select: 0 steady, 1 fast, 2 normal, 3 short flicker.
// - With buzzer enable set, the buzzer sounds the selected pattern.
// - Buzzer select: 0 continuous, 1 short, 2 normal, 3 long beep.
`default_nettype none
module dlb_ctrl (
  input wire logic aclk, // system clock, 10 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [9:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, ignored
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [9:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, ignored
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic diagnostic_indicator, // LED drive, active high
  output logic buzzer // buzzer drive, active high
);
  import dlb_pkg::*;

  function automatic logic [7:0] dlb_word_idx(input logic [9:0] addr);
    return addr[9:2];
  endfunction : dlb_word_idx

  function automatic logic [9:0] dlb_ms(input int ms);
    return ms[9:0];
  endfunction : dlb_ms

  logic [7:0] led_ctrl_r;
  logic [7:0] buz_ctrl_r;
  logic [9:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic [15:0] div_r;
  logic tick_r;
  logic led_pat;
  logic buz_pat;
  dlb_ctrl_s led_c;
  dlb_ctrl_s buz_c;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic do_write;

  assign widx = dlb_word_idx(awaddr_r);
  assign ridx = dlb_word_idx(s_axi_araddr);
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // Write address and data are captured independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Only the three defined bits are stored; the others read back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_ctrl_r <= DLB_CTRL_RST;
      buz_ctrl_r <= DLB_CTRL_RST;
    end else if (do_write && wstrb_r[0]) begin
      if (widx == DLB_IDX_LED) begin
        led_ctrl_r <= wdata_r[7:0] & DLB_CTRL_MASK;
      end
      if (widx == DLB_IDX_BUZ) begin
        buz_ctrl_r <= wdata_r[7:0] & DLB_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DLB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (widx == DLB_IDX_LED || widx == DLB_IDX_BUZ) ? DLB_RESP_OKAY
                                                                   : DLB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= DLB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= DLB_RESP_OKAY;
      if (ridx == DLB_IDX_LED) begin
        s_axi_rdata <= {24'h00_0000, led_ctrl_r};
      end else if (ridx == DLB_IDX_BUZ) begin
        s_axi_rdata <= {24'h00_0000, buz_ctrl_r};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= DLB_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Fixed divider gives a 1 ms enable for both pattern generators.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (div_r == 16'(DLB_TICK_CYC - 1)) begin
      div_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  assign led_c.enable = led_ctrl_r[DLB_EN_BIT];
  assign led_c.sel = {led_ctrl_r[DLB_SEL_HI_BIT], led_ctrl_r[DLB_SEL_LO_BIT]};
  assign buz_c.enable = buz_ctrl_r[DLB_EN_BIT];
  assign buz_c.sel = {buz_ctrl_r[DLB_SEL_HI_BIT], buz_ctrl_r[DLB_SEL_LO_BIT]};

  // Select 0 is steady; 1 fast, 2 normal, 3 short flicker.
  dlb_pattern u_led (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_r),
    .ctrl(led_c),
    .on_1(dlb_ms(DLB_FAST_HALF_MS)),
    .on_2(dlb_ms(DLB_NORM_HALF_MS)),
    .on_3(dlb_ms(DLB_SHORT_ON_MS)),
    .per_1(dlb_ms(2 * DLB_FAST_HALF_MS)),
    .per_2(dlb_ms(2 * DLB_NORM_HALF_MS)),
    .per_3(dlb_ms(DLB_SHORT_PER_MS)),
    .out_r(led_pat)
  );

  // Select 0 is continuous; 1 short, 2 normal, 3 long beep.
  dlb_pattern u_buz (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_r),
    .ctrl(buz_c),
    .on_1(dlb_ms(DLB_BEEP_SHORT_MS)),
    .on_2(dlb_ms(DLB_BEEP_NORM_MS)),
    .on_3(dlb_ms(DLB_BEEP_LONG_MS)),
    .per_1(dlb_ms(DLB_BEEP_PER_MS)),
    .per_2(dlb_ms(DLB_BEEP_PER_MS)),
    .per_3(dlb_ms(DLB_BEEP_PER_MS)),
    .out_r(buz_pat)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diagnostic_indicator <= 1'b0;
      buzzer <= 1'b0;
    end else begin
      diagnostic_indicator <= led_pat;
      buzzer <= buz_pat;
    end
  end
endmodule : dlb_ctrl
`default_nettype wire

/* File: hdl/dlb_pattern.sv */
`default_nettype none
module dlb_pattern (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic tick, // one-cycle 1 ms enable
  input wire dlb_pkg::dlb_ctrl_s ctrl, // enable and pattern select
  input wire logic [9:0] on_1, // on time for select 1
  input wire logic [9:0] on_2, // on time for select 2
  input wire logic [9:0] on_3, // on time for select 3
  input wire logic [9:0] per_1, // period for select 1
  input wire logic [9:0] per_2, // period for select 2
  input wire logic [9:0] per_3, // period for select 3
  output logic out_r // pattern output, registered
);
  import dlb_pkg::*;
  logic [9:0] cnt_r;
  logic [9:0] on_t;
  logic [9:0] per_t;

  always_comb begin
    unique case (dlb_sel_e'(ctrl.sel))
      DLB_SEL_ONE: begin
        on_t = on_1;
        per_t = per_1;
      end
      DLB_SEL_TWO: begin
        on_t = on_2;
        per_t = per_2;
      end
      DLB_SEL_THREE: begin
        on_t = on_3;
        per_t = per_3;
      end
      DLB_SEL_STEADY: begin
        on_t = per_1;
        per_t = per_1;
      end
    endcase
  end

  // Restarting the phase on disable makes each enable begin with an on phase.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.enable) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= (cnt_r >= per_t - 10'd1) ? '0 : cnt_r + 10'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= ctrl.enable && (ctrl.sel == 2'd0 || cnt_r < on_t);
    end
  end
endmodule : dlb_pattern
`default_nettype wire

/* File: hdl/dlb_pkg.sv */
`default_nettype none
package dlb_pkg;
  // Register word indices; addr[9:2] selects the register, so the byte address is four times each.
  localparam logic [7:0] DLB_IDX_LED = 8'h62;
  localparam logic [7:0] DLB_IDX_BUZ = 8'h63;
  localparam int DLB_ADDR_W = 10;
  localparam int DLB_EN_BIT = 0;
  localparam int DLB_SEL_LO_BIT = 1;
  localparam int DLB_SEL_HI_BIT = 2;
  localparam logic [7:0] DLB_CTRL_RST = 8'h00;
  localparam logic [7:0] DLB_CTRL_MASK = 8'h07;
  localparam logic [1:0] DLB_RESP_OKAY = 2'b00;
  localparam logic [1:0] DLB_RESP_SLVERR = 2'b10;
  // Clock and pattern timing.
  localparam int DLB_CLK_HZ = 10_000_000;
  localparam int DLB_TICK_US = 1_000;
  localparam int DLB_TICK_CYC = DLB_CLK_HZ / 1_000_000 * DLB_TICK_US;
  // Pattern figures in milliseconds (ticks of 1 ms).
  localparam int DLB_FAST_HALF_MS = 100;
  localparam int DLB_NORM_HALF_MS = 500;
  localparam int DLB_SHORT_ON_MS = 50;
  localparam int DLB_SHORT_PER_MS = 1_000;
  localparam int DLB_BEEP_SHORT_MS = 100;
  localparam int DLB_BEEP_NORM_MS = 300;
  localparam int DLB_BEEP_LONG_MS = 800;
  localparam int DLB_BEEP_PER_MS = 1_000;

  typedef enum logic [1:0] {
    DLB_SEL_STEADY,
    DLB_SEL_ONE,
    DLB_SEL_TWO,
    DLB_SEL_THREE
  } dlb_sel_e;

  typedef struct packed {
    logic enable;
    logic [1:0] sel;
  } dlb_ctrl_s;
endpackage : dlb_pkg
`default_nettype wire

/* File: verif/dlb_ctrl_bench.sv */
`default_nettype none
module dlb_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dlb_pkg::*;
  localparam logic [9:0] LED_A = {DLB_IDX_LED, 2'b00};
  localparam logic [9:0] BUZ_A = {DLB_IDX_BUZ, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic diagnostic_indicator, buzzer;
  int failures = 0, n_tests = 0, cyc = 0;
  dlb_ctrl u_dut (.*);
  always #50 aclk = ~aclk;
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r, input int hold = 0);
    bit aw = 1, w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (hold == 0);
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // A late bready shows that the response waits for the master.
    if (hold > 0) begin
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      repeat (hold) @(posedge aclk);
      chk(s_axi_bvalid, 1);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Expected on time and period, in 1 ms ticks, for a select other than steady.
  function automatic logic [31:0] exp_time(input bit b, input int s, input bit per);
    int on_ms;
    int per_ms;
    if (b) begin
      per_ms = DLB_BEEP_PER_MS;
      on_ms = (s == 1) ? DLB_BEEP_SHORT_MS : (s == 2) ? DLB_BEEP_NORM_MS : DLB_BEEP_LONG_MS;
    end else begin
      per_ms = (s == 1) ? 2 * DLB_FAST_HALF_MS
             : (s == 2) ? 2 * DLB_NORM_HALF_MS : DLB_SHORT_PER_MS;
      on_ms = (s == 1) ? DLB_FAST_HALF_MS : (s == 2) ? DLB_NORM_HALF_MS : DLB_SHORT_ON_MS;
    end
    return per ? 32'(per_ms) : 32'(on_ms);
  endfunction : exp_time
  task automatic t_pat(input logic [9:0] a, input bit b);
    logic [1:0] r;
    logic [31:0] d;
    for (int s = 0; s < 4; s++) begin
      axi_wr(a, {29'h0, 2'(s), 1'b1}, 4'hF, r);
      chk(r, DLB_RESP_OKAY);
      axi_rd(a, d, r);
      chk(d, {29'h0, 2'(s), 1'b1});
      if (s != 0) begin
        chk(b ? u_dut.u_buz.on_t : u_dut.u_led.on_t, exp_time(b, s, 0));
        chk(b ? u_dut.u_buz.per_t : u_dut.u_led.per_t, exp_time(b, s, 1));
      end
      repeat (20) @(posedge aclk);
      chk(b ? buzzer : diagnostic_indicator, 1);
      chk(b ? diagnostic_indicator : buzzer, 0);
      axi_wr(a, 32'h0000_0000, 4'hF, r);
      repeat (3) @(posedge aclk);
      chk(b ? buzzer : diagnostic_indicator, 0);
    end
  endtask : t_pat
  // A whole fast-blink period (select 1) is too long to run, so one tick interval is timed instead.
  task automatic t_tick;
    logic [1:0] r;
    int n;
    n = 0;
    axi_wr(LED_A, 32'h0000_0003, 4'hF, r);
    do @(posedge aclk); while (u_dut.tick_r !== 1'b1);
    do begin
      @(posedge aclk);
      n++;
    end while (u_dut.tick_r !== 1'b1);
    chk(n, DLB_TICK_CYC);
    chk(32'(u_dut.u_led.cnt_r != 10'h000), 32'h0000_0001);
    chk(diagnostic_indicator, 1);
    axi_wr(LED_A, 32'h0000_0000, 4'hF, r);
  endtask : t_tick
  task automatic t_map;
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(LED_A, 32'hFFFF_FFFF, 4'hF, r);
    axi_rd(LED_A, d, r);
    chk(d, 32'h0000_0007);
    axi_wr(LED_A, 32'h0000_0000, 4'hE, r);
    axi_rd(LED_A, d, r);
    chk(d, 32'h0000_0007);
    axi_wr(10'h3FC, 32'h0000_0001, 4'hF, r);
    chk(r, DLB_RESP_SLVERR);
    axi_rd(10'h3FC, d, r);
    chk({d[31:2], r}, {30'h0, DLB_RESP_SLVERR});
    axi_wr(BUZ_A, 32'h0000_0005, 4'hF, r, 4);
    chk(r, DLB_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(LED_A, d, r);
    chk({d[2:0], diagnostic_indicator, buzzer}, 5'h00);
  endtask : t_map
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(BUZ_A, d, r);
    chk(d, 32'h0000_0000);
    chk({buzzer, diagnostic_indicator}, 2'h0);
    t_pat(LED_A, 0);
    t_pat(BUZ_A, 1);
    t_tick();
    t_map();
    wrap_up();
  end
endmodule : dlb_ctrl_bench
`default_nettype wire

/* File: verif/dlb_ctrl_chk.sv */
`default_nettype none
module dlb_ctrl_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [9:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // w data
  input wire logic [3:0] s_axi_wstrb, // w strobes
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [9:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic diagnostic_indicator, // LED
  input wire logic buzzer // buzzer
);
  timeunit 1ns;
  timeprecision 1ns;
  import dlb_pkg::*;
  localparam logic [9:0] LED_A = {DLB_IDX_LED, 2'b00};
  localparam logic [9:0] BUZ_A = {DLB_IDX_BUZ, 2'b00};
  logic [9:0] aw_r;
  logic [9:0] ar_r;
  logic [2:0] wd_r;
  logic [2:0] led_r;
  logic [2:0] buz_r;
  logic ws_r;
  logic bv_r;
  // Shadows commit one edge after the design does, so the windows below allow for it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_r <= 3'h0;
      buz_r <= 3'h0;
      bv_r <= 1'b0;
    end else begin
      bv_r <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[2:0];
      if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[0];
      if (s_axi_bvalid && !bv_r && ws_r && aw_r == LED_A) led_r <= wd_r;
      if (s_axi_bvalid && !bv_r && ws_r && aw_r == BUZ_A) buz_r <= wd_r;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  AST_BRESP: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
    ((aw_r == LED_A || aw_r == BUZ_A) ? DLB_RESP_OKAY : DLB_RESP_SLVERR))
    else $error("bad bresp");
  AST_RD_UNUSED: assert property (s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0)
    else $error("unused bits read nonzero");
  AST_RD_VAL: assert property ($rose(s_axi_rvalid) &&
    (ar_r == LED_A || ar_r == BUZ_A) |->
    s_axi_rdata[2:0] == (ar_r == LED_A ? led_r : buz_r)) else $error("read value wrong");
  AST_LED_ON: assert property ($rose(led_r[0]) |-> ##[0:2] diagnostic_indicator)
    else $error("LED not lit after enable");
  AST_LED_OFF: assert property (!led_r[0] [*3] |-> !diagnostic_indicator)
    else $error("LED lit while disabled");
  AST_BUZ_ON: assert property ($rose(buz_r[0]) |-> ##[0:2] buzzer)
    else $error("buzzer silent after enable");
  AST_BUZ_OFF: assert property (!buz_r[0] [*3] |-> !buzzer)
    else $error("buzzer on while disabled");
  cover property ($rose(led_r[0]));
  cover property ($rose(buz_r[0]));
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == DLB_RESP_SLVERR);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule : dlb_ctrl_chk
bind dlb_ctrl dlb_ctrl_chk u_chk (.*);
`default_nettype wire
